// ==== src/accel_pkg.sv ====
// Shared constants and carrier types of the accelerometer readout block.
// Assumes a 50 MHz system clock and a serial link on a clock of its own.
// Behaviour
// - Bus address is 0x1D with select pin low, 0x53 with it high.
// - Axis data left justified, most significant byte at the lowest address.
// - Temperature is 12-bit unsigned right justified over two live bytes.
// - Axis registers always show the newest data, no cross-axis coherence.
// - Burst address increments per byte and sticks at the top address.
// - Burst address increments up to the queue address and holds there.
// - Queue streams: when full, new entries overwrite the oldest.
// - Queue holds 96 entries of 20 data bits plus an x-axis marker.
// - Queue reads pop on the first byte and every third byte after.
// - Queue word is sample, two zero bits, empty bit, x marker bit.
// - Axis registers are read from the newest set held in the queue.
// - Four flags route to either interrupt pin, with selectable polarity.
// - Flags clear on a status read unless their cause persists.
// - Data-ready sets on new data, clears on read until newer data.
// - Data-ready clear is delayed four internal 512 kHz cycles.
// - Ready pin sets on data, clears on data read or at half period.
// - Ready pin is always active high, polarity bit ignored.
// - Full flag follows entry count reaching the programmed threshold.
// - Overrun sets only on lost data, clears on a status read.
// - Motion flag sets after the programmed run of over-threshold samples.
// - Motion flag clears on read, sets again at next qualifying sample.
// - Memory-busy flag clears only by a read made after busy ends.
package accel_pkg;

	// Timing.
	localparam int unsigned CLK_HZ            = 50_000_000;
	localparam int unsigned INT_CLK_HZ        = 512_000;
	localparam int unsigned READY_CLR_TICKS   = 4;
	localparam int unsigned READY_CLR_CYCLES  =
		(READY_CLR_TICKS * CLK_HZ) / INT_CLK_HZ;

	// Sizes.
	localparam int unsigned FIFO_DEPTH  = 96;
	localparam int unsigned SAMPLE_W    = 20;
	localparam int unsigned TEMP_W      = 12;
	localparam int unsigned INTERVAL_W  = 24;

	// Bus addresses.
	localparam logic [6:0] BUS_ADDR_LOW  = 7'h1D;
	localparam logic [6:0] BUS_ADDR_HIGH = 7'h53;

	// Register addresses.
	localparam logic [9:0] ADDR_FLAGS     = 10'h004;
	localparam logic [9:0] ADDR_ENTRIES   = 10'h005;
	localparam logic [9:0] ADDR_TEMP_HI   = 10'h006;
	localparam logic [9:0] ADDR_TEMP_LO   = 10'h007;
	localparam logic [9:0] ADDR_AXIS_BASE = 10'h008;
	localparam logic [9:0] ADDR_AXIS_LAST = 10'h010;
	localparam logic [9:0] ADDR_FIFO      = 10'h011;
	localparam logic [9:0] ADDR_MOT_AXES  = 10'h024;
	localparam logic [9:0] ADDR_THR_HI    = 10'h025;
	localparam logic [9:0] ADDR_THR_LO    = 10'h026;
	localparam logic [9:0] ADDR_MOT_COUNT = 10'h027;
	localparam logic [9:0] ADDR_FILL      = 10'h029;
	localparam logic [9:0] ADDR_ROUTE     = 10'h02A;
	localparam logic [9:0] ADDR_RANGE     = 10'h02C;
	localparam logic [9:0] ADDR_TOP       = 10'h3FF;

	// Reset values.
	localparam logic [6:0] FILL_RST      = 7'h60;
	localparam logic [7:0] MOT_COUNT_RST = 8'h01;
	localparam logic [7:0] RANGE_RST     = 8'h81;

	// Field positions.
	localparam int unsigned FLAG_READY  = 0;
	localparam int unsigned FLAG_FULL   = 1;
	localparam int unsigned FLAG_OVR    = 2;
	localparam int unsigned FLAG_MOTION = 3;
	localparam int unsigned FLAG_NVM    = 4;
	localparam int unsigned POL_BIT     = 6;

	typedef struct packed {
		logic [SAMPLE_W-1:0] x;
		logic [SAMPLE_W-1:0] y;
		logic [SAMPLE_W-1:0] z;
	} axes_t;

	typedef struct packed {
		logic [SAMPLE_W-1:0] data;
		logic                marker;
	} fifo_entry_t;

endpackage : accel_pkg

// ==== src/accel_readout.sv ====
// Readout, sample queue and event flags of a three-axis accelerometer.
// Assumes samples and memory-busy come from logic on clk.
`timescale 1ns/100ps
module accel_readout #(
	parameter int unsigned DEPTH      = accel_pkg::FIFO_DEPTH,
	parameter int unsigned INTERVAL_W = accel_pkg::INTERVAL_W
) (
	// Clock and reset
	input  wire logic                          clk,
	input  wire logic                          rst,
	// Serial link
	input  wire logic                          sclk,
	input  wire logic                          csN,
	input  wire logic                          mosi,
	output logic                               miso,
	// Sample source
	input  wire logic                          sampleValid,
	input  wire accel_pkg::axes_t              sampleSet,
	input  wire logic [accel_pkg::TEMP_W-1:0]  temperature,
	input  wire logic                          nvmBusy,
	// Pins
	input  wire logic                          busAddrSelectPin,
	output logic [6:0]                         busAddress,
	output logic                               irqPinA,
	output logic                               irqPinB,
	output logic                               sampleReadyPin
);

	localparam int PTR_W = $clog2(DEPTH + 1);
	localparam int CLR_W = $clog2(accel_pkg::READY_CLR_CYCLES + 1);
	localparam logic [PTR_W-1:0] DEPTH_P = PTR_W'(DEPTH);
	localparam logic [CLR_W-1:0] CLR_LOAD =
		CLR_W'(accel_pkg::READY_CLR_CYCLES - 1);

	typedef struct packed {
		accel_pkg::fifo_entry_t [DEPTH-1:0] mem;
		logic [PTR_W-1:0]      oldestEntryPointer;
		logic [PTR_W-1:0]      wrPtr;
		logic [PTR_W-1:0]      count;
		logic [PTR_W-1:0]      newestSetPointer;
		logic [23:0]           popWord;
		logic [1:0]            popPhase;
		logic [9:0]            addr;
		logic                  rd;
		logic                  cmdSeen;
		logic                  prep;
		logic [7:0]            txWord;
		logic                  csMeta;
		logic                  csSync;
		logic                  tgMeta;
		logic                  tgMid;
		logic                  tgSync;
		logic                  tgSeen;
		logic                  selMeta;
		logic                  selSync;
		logic [2:0]            motionAxes;
		logic [15:0]           motionThreshold;
		logic [7:0]            motionCount;
		logic [6:0]            fillLevel;
		logic [7:0]            route;
		logic [7:0]            range;
		logic [4:0]            flags;
		logic                  clrPend;
		logic [CLR_W-1:0]      clrCnt;
		logic [7:0]            motionRun;
		logic [INTERVAL_W-1:0] sinceSet;
		logic [INTERVAL_W-1:0] interval;
		logic                  readyPin;
		logic                  irqA;
		logic                  irqB;
		logic [6:0]            busAddr;
	} state_t;

	state_t     s_q;
	state_t     s_d;
	logic [7:0] rxByte;
	logic       rxToggle;

	function automatic logic [PTR_W-1:0] wrapAdd(
		input logic [PTR_W-1:0] p,
		input logic [PTR_W-1:0] k
	);
		logic [PTR_W:0] s;
		s = {1'b0, p} + {1'b0, k};
		if (s >= {1'b0, DEPTH_P}) begin
			s = s - {1'b0, DEPTH_P};
		end
		return s[PTR_W-1:0];
	endfunction : wrapAdd

	function automatic logic [9:0] nextAddr(input logic [9:0] a);
		if (a == accel_pkg::ADDR_FIFO || a == accel_pkg::ADDR_TOP) begin
			return a;
		end
		return a + 10'h001;
	endfunction : nextAddr

	function automatic logic [15:0] magnitude(input logic [19:0] v);
		logic [19:0] m;
		m = v[19] ? (~v + 20'h0_0001) : v;
		return m[19:4];
	endfunction : magnitude

	serial_link link (
		.sclk     (sclk),
		.csN      (csN),
		.mosi     (mosi),
		.miso     (miso),
		.rxByte   (rxByte),
		.rxToggle (rxToggle),
		.txWord   (s_q.txWord)
	);

	always_comb begin
		logic                   byteEv;
		logic                   statusRead;
		logic                   dataRead;
		logic                   doPop;
		logic                   popOk;
		logic                   ovrEvent;
		logic                   over;
		logic                   irqActA;
		logic                   irqActB;
		logic [23:0]            popped;
		logic [PTR_W-1:0]       rdA;
		logic [PTR_W-1:0]       cntA;
		logic [PTR_W:0]         tot;
		logic [3:0]             idx;
		logic [19:0]            entry;
		logic [7:0]             rdByte;
		logic [8:0]             runNext;
		accel_pkg::fifo_entry_t head;
		byteEv     = 1'b0;
		statusRead = 1'b0;
		dataRead   = 1'b0;
		doPop      = 1'b0;
		popOk      = 1'b0;
		ovrEvent   = 1'b0;
		over       = 1'b0;
		irqActA    = 1'b0;
		irqActB    = 1'b0;
		popped     = 24'h00_0000;
		rdA        = '0;
		cntA       = '0;
		tot        = '0;
		idx        = 4'h0;
		entry      = 20'h0_0000;
		rdByte     = 8'h00;
		runNext    = 9'h000;
		head       = '0;
		s_d        = s_q;

		// Pin and link crossings. The toggle takes one stage more than the
		// frame select, so the toggle drop at frame end is never an event.
		s_d.csMeta  = csN;
		s_d.csSync  = s_q.csMeta;
		s_d.tgMeta  = rxToggle;
		s_d.tgMid   = s_q.tgMeta;
		s_d.tgSync  = s_q.tgMid;
		s_d.tgSeen  = s_q.tgSync;
		s_d.selMeta = busAddrSelectPin;
		s_d.selSync = s_q.selMeta;
		s_d.busAddr = s_q.selSync ? accel_pkg::BUS_ADDR_HIGH
			: accel_pkg::BUS_ADDR_LOW;

		byteEv = !s_q.csSync && (s_q.tgSync != s_q.tgSeen);
		s_d.prep = 1'b0;
		if (s_q.csSync) begin
			s_d.cmdSeen = 1'b0;
		end

		// Completed bytes: the first is the command, the rest are data.
		if (byteEv && !s_q.cmdSeen) begin
			s_d.addr     = {3'b000, rxByte[7:1]};
			s_d.rd       = rxByte[0];
			s_d.cmdSeen  = 1'b1;
			s_d.popPhase = 2'b00;
			s_d.prep     = rxByte[0];
		end else if (byteEv && s_q.rd) begin
			if (s_q.addr == accel_pkg::ADDR_FLAGS) begin
				statusRead = 1'b1;
			end else if (s_q.addr >= accel_pkg::ADDR_AXIS_BASE
				&& s_q.addr <= accel_pkg::ADDR_AXIS_LAST) begin
				dataRead = 1'b1;
			end else if (s_q.addr == accel_pkg::ADDR_FIFO) begin
				dataRead = 1'b1;
				s_d.popPhase = (s_q.popPhase == 2'b10) ? 2'b00
					: s_q.popPhase + 2'b01;
			end
			s_d.addr = nextAddr(s_q.addr);
			s_d.prep = 1'b1;
		end else if (byteEv) begin
			if (s_q.addr == accel_pkg::ADDR_MOT_AXES) begin
				s_d.motionAxes = rxByte[2:0];
			end else if (s_q.addr == accel_pkg::ADDR_THR_HI) begin
				s_d.motionThreshold[15:8] = rxByte;
			end else if (s_q.addr == accel_pkg::ADDR_THR_LO) begin
				s_d.motionThreshold[7:0] = rxByte;
			end else if (s_q.addr == accel_pkg::ADDR_MOT_COUNT) begin
				s_d.motionCount = rxByte;
			end else if (s_q.addr == accel_pkg::ADDR_FILL) begin
				s_d.fillLevel = rxByte[6:0];
			end else if (s_q.addr == accel_pkg::ADDR_ROUTE) begin
				s_d.route = rxByte;
			end else if (s_q.addr == accel_pkg::ADDR_RANGE) begin
				s_d.range = rxByte;
			end
			s_d.addr = nextAddr(s_q.addr);
		end

		// Queue: the head is only copied while its first byte is made ready
		// and leaves once that byte has gone out, so a frame that stops on
		// a word boundary loses nothing. Then stream writes.
		doPop = s_q.prep && (s_q.addr == accel_pkg::ADDR_FIFO)
			&& (s_q.popPhase == 2'b00);
		head = s_q.mem[s_q.oldestEntryPointer];
		popped = (s_q.count != '0) ? {head.data, 2'b00, 1'b0, head.marker}
			: {20'h0_0000, 2'b00, 1'b1, 1'b0};
		if (doPop) begin
			s_d.popWord = popped;
		end
		popOk = byteEv && s_q.cmdSeen && s_q.rd && !s_q.popWord[1]
			&& (s_q.addr == accel_pkg::ADDR_FIFO)
			&& (s_q.popPhase == 2'b00) && (s_q.count != '0);
		rdA = popOk ? wrapAdd(s_q.oldestEntryPointer, PTR_W'(1))
			: s_q.oldestEntryPointer;
		cntA = s_q.count - PTR_W'(popOk);
		if (sampleValid) begin
			s_d.mem[s_q.wrPtr] = {sampleSet.x, 1'b1};
			s_d.mem[wrapAdd(s_q.wrPtr, PTR_W'(1))] = {sampleSet.y, 1'b0};
			s_d.mem[wrapAdd(s_q.wrPtr, PTR_W'(2))] = {sampleSet.z, 1'b0};
			s_d.newestSetPointer = s_q.wrPtr;
			s_d.wrPtr = wrapAdd(s_q.wrPtr, PTR_W'(3));
			tot = {1'b0, cntA} + (PTR_W+1)'(3);
			if (tot > {1'b0, DEPTH_P}) begin
				// Stream mode: drop the oldest entries to make room.
				rdA = wrapAdd(rdA, PTR_W'(tot - {1'b0, DEPTH_P}));
				s_d.count = DEPTH_P;
				ovrEvent = 1'b1;
			end else begin
				s_d.count = tot[PTR_W-1:0];
			end
		end else begin
			s_d.count = cntA;
		end
		s_d.oldestEntryPointer = rdA;

		// Answer byte for the current address, settled after each byte.
		idx = 4'(s_q.addr - accel_pkg::ADDR_AXIS_BASE);
		entry = s_q.mem[wrapAdd(s_q.newestSetPointer,
			PTR_W'(idx / 4'h3))].data;
		if (s_q.addr == accel_pkg::ADDR_FLAGS) begin
			rdByte = {3'b000, s_q.flags};
		end else if (s_q.addr == accel_pkg::ADDR_ENTRIES) begin
			rdByte = 8'(s_q.count);
		end else if (s_q.addr == accel_pkg::ADDR_TEMP_HI) begin
			rdByte = {4'h0, temperature[11:8]};
		end else if (s_q.addr == accel_pkg::ADDR_TEMP_LO) begin
			rdByte = temperature[7:0];
		end else if (s_q.addr >= accel_pkg::ADDR_AXIS_BASE
			&& s_q.addr <= accel_pkg::ADDR_AXIS_LAST) begin
			if (idx % 4'h3 == 4'h0) begin
				rdByte = entry[19:12];
			end else if (idx % 4'h3 == 4'h1) begin
				rdByte = entry[11:4];
			end else begin
				rdByte = {entry[3:0], 4'h0};
			end
		end else if (s_q.addr == accel_pkg::ADDR_FIFO) begin
			if (s_q.popPhase == 2'b00) begin
				rdByte = popped[23:16];
			end else if (s_q.popPhase == 2'b01) begin
				rdByte = s_q.popWord[15:8];
			end else begin
				rdByte = s_q.popWord[7:0];
			end
		end else if (s_q.addr == accel_pkg::ADDR_MOT_AXES) begin
			rdByte = {5'b00000, s_q.motionAxes};
		end else if (s_q.addr == accel_pkg::ADDR_THR_HI) begin
			rdByte = s_q.motionThreshold[15:8];
		end else if (s_q.addr == accel_pkg::ADDR_THR_LO) begin
			rdByte = s_q.motionThreshold[7:0];
		end else if (s_q.addr == accel_pkg::ADDR_MOT_COUNT) begin
			rdByte = s_q.motionCount;
		end else if (s_q.addr == accel_pkg::ADDR_FILL) begin
			rdByte = {1'b0, s_q.fillLevel};
		end else if (s_q.addr == accel_pkg::ADDR_ROUTE) begin
			rdByte = s_q.route;
		end else if (s_q.addr == accel_pkg::ADDR_RANGE) begin
			rdByte = s_q.range;
		end
		if (s_q.prep) begin
			s_d.txWord = rdByte;
		end

		// Data-ready: a read only arms a delayed clear, and fresh data
		// cancels it, so a sample landing during the read is not lost.
		if (s_q.clrPend) begin
			if (s_q.clrCnt == '0) begin
				s_d.flags[accel_pkg::FLAG_READY] = 1'b0;
				s_d.clrPend = 1'b0;
			end else begin
				s_d.clrCnt = s_q.clrCnt - CLR_W'(1);
			end
		end
		if (statusRead) begin
			s_d.clrPend = 1'b1;
			s_d.clrCnt = CLR_LOAD;
			s_d.flags[accel_pkg::FLAG_OVR] = 1'b0;
			s_d.flags[accel_pkg::FLAG_MOTION] = 1'b0;
		end
		if (sampleValid) begin
			s_d.flags[accel_pkg::FLAG_READY] = 1'b1;
			s_d.clrPend = 1'b0;
		end
		if (ovrEvent) begin
			s_d.flags[accel_pkg::FLAG_OVR] = 1'b1;
		end

		// Motion run counts consecutive samples with any enabled axis over limit.
		if (sampleValid) begin
			over = (s_q.motionAxes[0]
				&& magnitude(sampleSet.x) > s_q.motionThreshold)
				|| (s_q.motionAxes[1]
				&& magnitude(sampleSet.y) > s_q.motionThreshold)
				|| (s_q.motionAxes[2]
				&& magnitude(sampleSet.z) > s_q.motionThreshold);
			runNext = {1'b0, s_q.motionRun} + 9'h001;
			s_d.motionRun = over ? (runNext[8] ? 8'hFF : runNext[7:0])
				: 8'h00;
			if (over && runNext >= {1'b0, s_q.motionCount}) begin
				s_d.flags[accel_pkg::FLAG_MOTION] = 1'b1;
			end
		end

		s_d.flags[accel_pkg::FLAG_FULL] = s_d.count >= s_q.fillLevel;
		s_d.flags[accel_pkg::FLAG_NVM] = nvmBusy
			|| (s_q.flags[accel_pkg::FLAG_NVM] && !statusRead);

		// Ready pin: autoclear halfway through the measured sample period.
		if (s_q.sinceSet != '1) begin
			s_d.sinceSet = s_q.sinceSet + INTERVAL_W'(1);
		end
		if (dataRead || (s_q.interval != '0
			&& s_q.sinceSet >= (s_q.interval >> 1))) begin
			s_d.readyPin = 1'b0;
		end
		if (sampleValid) begin
			s_d.interval = s_d.sinceSet;
			s_d.sinceSet = '0;
			s_d.readyPin = 1'b1;
		end

		irqActA = |(s_d.flags[3:0] & s_d.route[3:0]);
		irqActB = |(s_d.flags[3:0] & s_d.route[7:4]);
		s_d.irqA = s_d.range[accel_pkg::POL_BIT] ? irqActA : !irqActA;
		s_d.irqB = s_d.range[accel_pkg::POL_BIT] ? irqActB : !irqActB;

		if (rst) begin
			s_d             = '0;
			s_d.csMeta      = 1'b1;
			s_d.csSync      = 1'b1;
			s_d.fillLevel   = accel_pkg::FILL_RST;
			s_d.motionCount = accel_pkg::MOT_COUNT_RST;
			s_d.sinceSet    = '1;
			s_d.range       = accel_pkg::RANGE_RST;
			s_d.busAddr     = accel_pkg::BUS_ADDR_LOW;
		end
	end

	always_ff @(posedge clk) begin
		s_q <= s_d;
	end

	assign busAddress     = s_q.busAddr;
	assign irqPinA        = s_q.irqA;
	assign irqPinB        = s_q.irqB;
	assign sampleReadyPin = s_q.readyPin;

endmodule : accel_readout

// ==== src/serial_link.sv ====
// Serial shifter on the link clock, mode 0, most significant bit first.
// Assumes the host pauses with the clock high after each eighth rising edge.
`timescale 1ns/100ps
module serial_link (
	// Link pins
	input  wire logic       sclk,
	input  wire logic       csN,
	input  wire logic       mosi,
	output logic            miso,
	// Toward the system domain
	output logic [7:0]      rxByte,
	output logic            rxToggle,
	input  wire logic [7:0] txWord
);

	typedef struct packed {
		logic [2:0] bitCnt;
		logic [6:0] shiftIn;
		logic [7:0] rxByte;
		logic       rxToggle;
	} link_t;

	link_t      l_q;
	link_t      l_d;
	logic [7:0] txShift_q;

	// The frame select clears the link state, so no edge outside a frame
	// is ever needed to bring it back to a known value.
	always_comb begin
		l_d = l_q;
		l_d.bitCnt = l_q.bitCnt + 3'h1;
		l_d.shiftIn = {l_q.shiftIn[5:0], mosi};
		if (l_q.bitCnt == 3'h7) begin
			l_d.rxByte = {l_q.shiftIn, mosi};
			l_d.rxToggle = ~l_q.rxToggle;
		end
	end

	always_ff @(posedge sclk or posedge csN) begin
		if (csN) begin
			l_q <= '0;
		end else begin
			l_q <= l_d;
		end
	end

	// The answer word is taken on the falling edge that closes a byte. The
	// system side settles it during the host pause, so it is quiet here.
	always_ff @(negedge sclk or posedge csN) begin
		if (csN) begin
			txShift_q <= 8'h00;
		end else if (l_q.bitCnt == 3'h0) begin
			txShift_q <= txWord;
		end else begin
			txShift_q <= {txShift_q[6:0], 1'b0};
		end
	end

	assign miso     = txShift_q[7];
	assign rxByte   = l_q.rxByte;
	assign rxToggle = l_q.rxToggle;

endmodule : serial_link

// ==== testbench/accel_readout_asserts.sv ====
// Checker for the accelerometer readout: address pin, ready pin, link data.
// Assumes it is bound to accel_readout and sees only that module's ports.
`timescale 1ns/100ps
module accel_readout_asserts #(
	parameter int unsigned DEPTH      = accel_pkg::FIFO_DEPTH,
	parameter int unsigned INTERVAL_W = accel_pkg::INTERVAL_W
) (
	// Clock and reset
	input wire logic                         clk,
	input wire logic                         rst,
	// Serial link
	input wire logic                         sclk,
	input wire logic                         csN,
	input wire logic                         mosi,
	input wire logic                         miso,
	// Sample source
	input wire logic                         sampleValid,
	input wire accel_pkg::axes_t             sampleSet,
	input wire logic [accel_pkg::TEMP_W-1:0] temperature,
	input wire logic                         nvmBusy,
	// Pins
	input wire logic                         busAddrSelectPin,
	input wire logic [6:0]                   busAddress,
	input wire logic                         irqPinA,
	input wire logic                         irqPinB,
	input wire logic                         sampleReadyPin
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	logic [INTERVAL_W-1:0] gap_q;
	logic [INTERVAL_W-1:0] lastGap_q;
	logic [1:0]            pulses_q;
	logic [5:0]            idle_q;
	logic                  misoAtRise_q;

	// The host samples on the rising edge, so that bit must still stand
	// when the link clock falls again.
	always_ff @(posedge sclk) begin
		misoAtRise_q <= miso;
	end

	// Reads commit a few cycles after each byte, inside the frame, so idle_q keeps the
	// hold check away from any frame that could legally clear the pin.
	always_ff @(posedge clk) begin
		if (rst) begin
			gap_q <= '0;
			lastGap_q <= '0;
			pulses_q <= 2'h0;
			idle_q <= 6'h00;
		end else begin
			gap_q <= sampleValid ? '0 : gap_q + 1'h1;
			lastGap_q <= sampleValid ? gap_q : lastGap_q;
			if (sampleValid && pulses_q != 2'h2) begin
				pulses_q <= pulses_q + 2'h1;
			end
			if (!csN) begin
				idle_q <= 6'h00;
			end else if (idle_q != 6'h3F) begin
				idle_q <= idle_q + 6'h01;
			end
		end
	end

	sequence s_selLow;
		!busAddrSelectPin [*5];
	endsequence
	sequence s_selHigh;
		busAddrSelectPin [*5];
	endsequence

	AST_ADDR_LOW: assert property (s_selLow |-> busAddress == 7'h1D)
		else $error("bus address wrong with select pin low");
	AST_ADDR_HIGH: assert property (s_selHigh |-> busAddress == 7'h53)
		else $error("bus address wrong with select pin high");
	AST_ADDR_FOLLOW: assert property ($changed(busAddress) |->
		busAddress == (busAddrSelectPin ? 7'h53 : 7'h1D))
		else $error("bus address changed away from the pin choice");
	AST_RDY_SET: assert property (sampleValid |-> ##[1:4] sampleReadyPin)
		else $error("ready pin not raised after new sample");
	AST_RDY_CAUSE: assert property ($rose(sampleReadyPin) |->
		$past(sampleValid) || $past(sampleValid, 2) || $past(sampleValid, 3))
		else $error("ready pin rose without a sample");
	AST_RDY_AUTOCLR: assert property (pulses_q == 2'h2 &&
		gap_q == (lastGap_q >> 1) + 4'h4 |-> !sampleReadyPin)
		else $error("ready pin not cleared at half interval");
	AST_RDY_HOLD: assert property (sampleReadyPin && idle_q == 6'h3F &&
		(pulses_q != 2'h2 || gap_q + 4'h8 < (lastGap_q >> 1)) |=> sampleReadyPin)
		else $error("ready pin dropped without cause");
	AST_MISO_STABLE: assert property (@(negedge sclk) disable iff (csN)
		miso == misoAtRise_q)
		else $error("miso moved while link clock high");
endmodule : accel_readout_asserts

bind accel_readout accel_readout_asserts #(
	.DEPTH(DEPTH), .INTERVAL_W(INTERVAL_W)
) chk_u (
	.clk(clk), .rst(rst), .sclk(sclk), .csN(csN), .mosi(mosi), .miso(miso),
	.sampleValid(sampleValid), .sampleSet(sampleSet),
	.temperature(temperature), .nvmBusy(nvmBusy),
	.busAddrSelectPin(busAddrSelectPin), .busAddress(busAddress),
	.irqPinA(irqPinA), .irqPinB(irqPinB), .sampleReadyPin(sampleReadyPin)
);

// ==== testbench/spi_host_model.sv ====
// Host controller model on the four-wire link, clock idle low.
// Assumes the bench calls frame() and reads rxb afterwards.
`timescale 1ns/100ps
module spi_host_model (
	// Link pins
	output logic      sclk,
	output logic      csN,
	output logic      mosi,
	input  wire logic miso
);
	logic [7:0] rxb [0:15];

	initial begin
		sclk = 1'h0;
		csN = 1'h1;
		mosi = 1'h1;
	end

	// The long pause after each eighth edge gives the device time to
	// prepare the next answer byte before the falling edge shows it.
	task automatic frame(input logic [7:0] txb [0:15], input int n);
		#3.3 csN = 1'h0;
		#100;
		for (int b = 0; b < n; b++) begin
			for (int i = 7; i >= 0; i--) begin
				mosi = txb[b][i];
				#15 sclk = 1'h1;
				rxb[b][i] = miso;
				if (i > 0) begin
					#15 sclk = 1'h0;
				end
			end
			#300 sclk = 1'h0;
		end
		#100 csN = 1'h1;
		mosi = ~mosi;
		#200;
	endtask : frame
endmodule : spi_host_model

// ==== testbench/tb_accel_readout.sv ====
// Self-checking bench for the accelerometer readout block.
// Assumes the host model drives the link while the bench plays the sensor.
`timescale 1ns/100ps
module tb_accel_readout;
	logic                         clk = 1'h0;
	logic                         rst = 1'h1;
	logic                         sclk;
	logic                         csN;
	logic                         mosi;
	logic                         miso;
	logic                         sampleValid = 1'h0;
	accel_pkg::axes_t             sampleSet = '0;
	logic [accel_pkg::TEMP_W-1:0] temperature = 12'h000;
	logic                         nvmBusy = 1'h0;
	logic                         busAddrSelectPin = 1'h0;
	logic [6:0]                   busAddress;
	logic                         irqPinA;
	logic                         irqPinB;
	logic                         sampleReadyPin;
	logic [7:0]                   tx [0:15];
	int                           mismatches = 0;
	int                           nTests = 0;

	always #10 clk = ~clk;

	accel_readout dut_u (.clk(clk), .rst(rst), .sclk(sclk), .csN(csN),
		.mosi(mosi), .miso(miso), .sampleValid(sampleValid),
		.sampleSet(sampleSet), .temperature(temperature), .nvmBusy(nvmBusy),
		.busAddrSelectPin(busAddrSelectPin), .busAddress(busAddress),
		.irqPinA(irqPinA), .irqPinB(irqPinB), .sampleReadyPin(sampleReadyPin));
	spi_host_model host_u (.sclk(sclk), .csN(csN), .mosi(mosi), .miso(miso));

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", nTests, mismatches);
		if (mismatches == 0 && nTests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : tally_and_finish

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask : cyc

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		nTests++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic rdChk(input logic [9:0] a, input logic [7:0] e [$]);
		tx[0] = {a[6:0], 1'h1};
		host_u.frame(tx, e.size() + 1);
		foreach (e[i]) begin
			chk(host_u.rxb[i + 1], e[i]);
		end
	endtask : rdChk

	task automatic wr(input logic [9:0] a, input logic [7:0] d [$]);
		tx[0] = {a[6:0], 1'h0};
		foreach (d[i]) begin
			tx[i + 1] = d[i];
		end
		host_u.frame(tx, d.size() + 1);
	endtask : wr

	task automatic push(input logic [19:0] x, input logic [19:0] y,
		input logic [19:0] z);
		cyc(1);
		sampleValid = 1'h1;
		sampleSet = {x, y, z};
		cyc(1);
		sampleValid = 1'h0;
		cyc(10);
	endtask : push

	task automatic t_addr();
		chk({1'h0, busAddress}, 8'h1D);
		busAddrSelectPin = 1'h1;
		cyc(6);
		chk({1'h0, busAddress}, 8'h53);
		busAddrSelectPin = 1'h0;
		cyc(6);
		chk({1'h0, busAddress}, 8'h1D);
	endtask : t_addr

	task automatic t_axes();
		logic [7:0] e [$];
		push(20'h1_2345, 20'hA_BCDE, 20'h0_F0F1);
		chk({7'h00, sampleReadyPin}, 8'h01);
		e = {8'h12, 8'h34, 8'h50, 8'hAB, 8'hCD, 8'hE0, 8'h0F, 8'h0F, 8'h10};
		e = {e, 8'h12, 8'h34, 8'h51};
		rdChk(10'h008, e);
		cyc(10);
		chk({7'h00, sampleReadyPin}, 8'h00);
		rdChk(10'h011, {8'hAB});
		e = {8'h0F, 8'h0F, 8'h10, 8'h00, 8'h00, 8'h02};
		rdChk(10'h011, e);
	endtask : t_axes

	task automatic t_temp();
		cyc(1);
		temperature = 12'hABC;
		rdChk(10'h006, {8'h0A, 8'hBC});
		rdChk(10'h07E, {8'h00});
	endtask : t_temp

	task automatic t_ready();
		push(20'h0_0000, 20'h0_0000, 20'h0_0000);
		rdChk(10'h004, {8'h01});
		rdChk(10'h004, {8'h01});
		cyc(450);
		rdChk(10'h004, {8'h00});
	endtask : t_ready

	task automatic t_motion();
		wr(10'h024, {8'h01, 8'h00, 8'h10, 8'h02});
		rdChk(10'h024, {8'h01, 8'h00, 8'h10, 8'h02});
		push(20'h0_0400, 20'h0_0000, 20'h0_0000);
		rdChk(10'h004, {8'h01});
		push(20'h0_0400, 20'h0_0000, 20'h0_0000);
		rdChk(10'h004, {8'h09});
		rdChk(10'h004, {8'h01});
		wr(10'h02A, {8'h18});
		push(20'hF_FC00, 20'h0_0000, 20'h0_0000);
		chk({6'h00, irqPinA, irqPinB}, 8'h00);
		wr(10'h02C, {8'hC1});
		cyc(5);
		chk({6'h00, irqPinA, irqPinB}, 8'h03);
		push(20'h0_0010, 20'h0_0000, 20'h0_0000);
		chk({7'h00, sampleReadyPin}, 8'h01);
		rdChk(10'h004, {8'h09});
		cyc(450);
		chk({6'h00, irqPinA, irqPinB}, 8'h00);
	endtask : t_motion

	task automatic t_overrun();
		for (int i = 0; i < 33; i++) begin
			push(20'(i * 3), 20'(i * 3 + 1), 20'(i * 3 + 2));
		end
		rdChk(10'h005, {8'h60});
		rdChk(10'h004, {8'h07});
		rdChk(10'h004, {8'h03});
		rdChk(10'h011, {8'h00, 8'h00, 8'h31});
		cyc(450);
		rdChk(10'h004, {8'h00});
	endtask : t_overrun

	task automatic t_nvm();
		cyc(1);
		nvmBusy = 1'h1;
		cyc(5);
		rdChk(10'h004, {8'h10});
		rdChk(10'h004, {8'h10});
		cyc(1);
		nvmBusy = 1'h0;
		cyc(5);
		rdChk(10'h004, {8'h10});
		rdChk(10'h004, {8'h00});
	endtask : t_nvm

	initial begin
		#1_500_000;
		mismatches++;
		tally_and_finish();
	end

	initial begin
		cyc(10);
		rst = 1'h0;
		cyc(5);
		t_addr();
		t_axes();
		t_temp();
		t_ready();
		t_motion();
		t_overrun();
		t_nvm();
		tally_and_finish();
	end
endmodule : tb_accel_readout
